//--- swss_pkg.sv
package swss_pkg;

    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int CLK_MHZ                 = 250;
    localparam int RESET_LOW_TIME_US       = 480;
    localparam int PRESENCE_WAIT_TIME_US   = 30;
    localparam int PRESENCE_LOW_TIME_US    = 120;
    localparam int READ_VALID_WINDOW_US    = 15;
    localparam int SLAVE_RELEASE_TIME_US   = 30;
    localparam int SAMPLE_TIME_US          = 30;
    localparam int SUSPEND_LIMIT_US        = 120;

    localparam int RESET_LOW_CYCLES        = RESET_LOW_TIME_US * CLK_MHZ;
    localparam int PRESENCE_WAIT_CYCLES    = PRESENCE_WAIT_TIME_US * CLK_MHZ;
    localparam int PRESENCE_LOW_CYCLES     = PRESENCE_LOW_TIME_US * CLK_MHZ;
    localparam int READ_HOLD_CYCLES        = SLAVE_RELEASE_TIME_US * CLK_MHZ;
    localparam int SAMPLE_CYCLES           = SAMPLE_TIME_US * CLK_MHZ;
    localparam int TIMER_W                 = 18;
    localparam int SYNC_STAGES             = 3;

    localparam int FIFO_WIDTH              = 1;
    localparam int FIFO_DEPTH              = 16;
    localparam logic [TIMER_W-1:0] TIMER_RESET = 18'h00000;

    // ------------------------------------------------------------
    // Types
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        SW_IDLE,
        SW_RESET_LOW,
        SW_PRESENCE_WAIT,
        SW_PRESENCE_LOW,
        SW_SLOT,
        SW_SLOT_END
    } swss_state_t;

    typedef struct packed {
        logic bitValue;
        logic valid;
    } swss_bit_t;

endpackage : swss_pkg

//--- swss_fifo.sv
`timescale 1ns/10ps
module swss_fifo #(
    parameter int WIDTH = 1,
    parameter int DEPTH = 16
) (
    input  wire logic             sys_clk,
    input  wire logic             rstSync_n,
    input  wire logic [WIDTH-1:0] inData,
    input  wire logic             inValid,
    output      logic             inReady,
    output      logic [WIDTH-1:0] outData,
    output      logic             outValid,
    input  wire logic             outReady
);
    localparam int AW = $clog2(DEPTH);

    initial begin
        if (DEPTH < 2 || (1 << AW) != DEPTH) $error("swss_fifo depth must be a power of two");
    end

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW:0]      wrPtr;
    logic [AW:0]      rdPtr;

    wire doWrite = inValid && inReady;
    wire doRead  = outValid && outReady;

    assign inReady  = (wrPtr - rdPtr) != (AW+1)'(DEPTH);
    assign outValid = wrPtr != rdPtr;
    assign outData  = mem[rdPtr[AW-1:0]];

    always_ff @(posedge sys_clk) begin
        if (doWrite) begin
            mem[wrPtr[AW-1:0]] <= inData;
        end
    end

    always_ff @(posedge sys_clk or negedge rstSync_n) begin
        if (!rstSync_n) begin
            wrPtr <= '0;
            rdPtr <= '0;
        end else begin
            if (doWrite) wrPtr <= wrPtr + 1'b1;
            if (doRead)  rdPtr <= rdPtr + 1'b1;
        end
    end
endmodule : swss_fifo

//--- swss_link.sv
`timescale 1ns/10ps
// Function
// R01: Four signal kinds: reset/presence, write zero, write one, read.
// R02: Master resets with line low at least 480 us.
// R03: After reset rise wait 15-60 us, then pull low 60-240 us.
// R04: Master keeps reset low no longer than 960 us.
// R05: Master waits reset high time of 480 us before next activity.
// R06: Slots begin with master falling edge, starting slave delay timer.
// R07: Write slot: slave samples line once at timer point as bit.
// R08: Read slot: zero held low for timer period, one left alone.
// R09: Slave drives read data within 1 us of falling edge.
// R10: Line idles high; low over 120 us may reset devices.
// R11: Master sends short low for one, long low for zero.
module swss_link
    import swss_pkg::*;
#(
    parameter int RESET_LOW_CYC  = swss_pkg::RESET_LOW_CYCLES,
    parameter int PRES_WAIT_CYC  = swss_pkg::PRESENCE_WAIT_CYCLES,
    parameter int PRES_LOW_CYC   = swss_pkg::PRESENCE_LOW_CYCLES,
    parameter int READ_HOLD_CYC  = swss_pkg::READ_HOLD_CYCLES,
    parameter int SAMPLE_CYC     = swss_pkg::SAMPLE_CYCLES
) (
    input  wire logic sys_clk,
    input  wire logic rst_n,
    input  wire logic lineIn,
    output      logic lineOut,
    output      logic lineOe,
    output      logic rxBit,
    output      logic rxValid,
    input  wire logic rxReady,
    input  wire logic txBit,
    input  wire logic txValid,
    output      logic txReady,
    output      logic resetSeen,
    output      logic rxOverflow
);
    import swss_pkg::*;

    initial begin
        if (SAMPLE_CYC >= PRES_LOW_CYC || SAMPLE_CYC < 1 || READ_HOLD_CYC < 1 ||
            RESET_LOW_CYC >= (1 << TIMER_W) || PRES_LOW_CYC >= (1 << TIMER_W))
            $error("swss_link timing parameters out of range");
    end

    // ------------------------------------------------------------
    // Reset release and line synchroniser
    // ------------------------------------------------------------
    logic [1:0] rstPipe;
    logic       rstSync_n;
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) rstPipe <= 2'h0;
        else        rstPipe <= {rstPipe[0], 1'b1};
    end
    assign rstSync_n = rstPipe[1];

    logic [SYNC_STAGES-1:0] lineSync;
    logic                   lineLvl;
    always_ff @(posedge sys_clk or negedge rstSync_n) begin
        if (!rstSync_n) begin
            lineSync <= 3'h7;
            lineLvl  <= 1'b1;
        end else begin
            lineSync <= {lineSync[1:0], lineIn};
            if (lineSync[1] == lineSync[2]) lineLvl <= lineSync[2];
        end
    end

    logic lineLvlQ;
    always_ff @(posedge sys_clk or negedge rstSync_n) begin
        if (!rstSync_n) lineLvlQ <= 1'b1;
        else            lineLvlQ <= lineLvl;
    end
    wire fallEdge = lineLvlQ && !lineLvl;
    wire riseEdge = !lineLvlQ && lineLvl;

    // ------------------------------------------------------------
    // Received bit FIFO
    // ------------------------------------------------------------
    swss_bit_t rxPush;
    logic      fifoInReady;
    logic      fifoOut;
    swss_fifo #(.WIDTH(FIFO_WIDTH), .DEPTH(FIFO_DEPTH)) uFifo (
        .sys_clk   (sys_clk),
        .rstSync_n (rstSync_n),
        .inData    (rxPush.bitValue),
        .inValid   (rxPush.valid),
        .inReady   (fifoInReady),
        .outData   (fifoOut),
        .outValid  (rxValid),
        .outReady  (rxReady)
    );
    assign rxBit = fifoOut;

    // ------------------------------------------------------------
    // Slot and reset sequencer
    // ------------------------------------------------------------
    swss_state_t      state;
    swss_state_t      next_state;
    logic [TIMER_W-1:0] timer;
    logic [TIMER_W-1:0] next_timer;
    logic             txLatched;
    logic             readSlot;
    logic             next_readSlot;
    logic             txHeld;
    logic             pullLow;
    logic             resetSeenR;
    logic             overflowR;

    // Timer starts a few cycles after the line falls; the margin keeps a minimum reset visible
    wire timerLong   = timer >= TIMER_W'(RESET_LOW_CYC - 2);
    wire sampleNow   = (state == SW_SLOT) && !readSlot && timer == TIMER_W'(SAMPLE_CYC); // [R07]
    wire holdDone    = timer >= TIMER_W'(READ_HOLD_CYC);

    assign rxPush.bitValue = lineLvl;
    assign rxPush.valid    = sampleNow && fifoInReady;
    assign txReady         = (state == SW_IDLE) && !txHeld;
    assign lineOut         = 1'b0;
    assign lineOe          = pullLow; // [R10]
    assign resetSeen       = resetSeenR;
    assign rxOverflow      = overflowR;

    always_comb begin
        next_state    = state;
        next_timer    = timer + 1'b1;
        next_readSlot = readSlot;
        unique case (state)
            SW_IDLE: begin
                next_timer = TIMER_RESET;
                if (fallEdge) begin // [R06]
                    next_state    = SW_SLOT;
                    next_readSlot = txHeld;
                end
            end
            SW_SLOT: begin
                if (!lineLvl && timerLong) begin
                    next_state = SW_RESET_LOW; // [R02]
                end else if (timer >= TIMER_W'(SAMPLE_CYC) && holdDone && lineLvl) begin
                    next_state = SW_IDLE;
                end
            end
            SW_RESET_LOW: begin
                if (riseEdge) begin // [R03]
                    next_state = SW_PRESENCE_WAIT;
                    next_timer = TIMER_RESET;
                end
            end
            SW_PRESENCE_WAIT: begin
                if (timer >= TIMER_W'(PRES_WAIT_CYC - 1)) begin // [R03]
                    next_state = SW_PRESENCE_LOW;
                    next_timer = TIMER_RESET;
                end
            end
            SW_PRESENCE_LOW: begin
                if (timer >= TIMER_W'(PRES_LOW_CYC - 1)) begin // [R03]
                    next_state = SW_SLOT_END;
                    next_timer = TIMER_RESET;
                end
            end
            SW_SLOT_END: begin
                next_timer = TIMER_RESET;
                if (lineLvl) next_state = SW_IDLE;
            end
        endcase
    end

    always_ff @(posedge sys_clk or negedge rstSync_n) begin
        if (!rstSync_n) begin
            state    <= SW_IDLE;
            timer    <= TIMER_RESET;
            readSlot <= 1'b0;
        end else begin
            state    <= next_state;
            timer    <= next_timer;
            readSlot <= next_readSlot;
        end
    end

    // Bit to send is latched while idle so the slot can answer at once
    always_ff @(posedge sys_clk or negedge rstSync_n) begin
        if (!rstSync_n) begin
            txHeld    <= 1'b0;
            txLatched <= 1'b1;
        end else if (next_state == SW_RESET_LOW) begin
            txHeld    <= 1'b0;
        end else if (txValid && txReady) begin
            txHeld    <= 1'b1;
            txLatched <= txBit;
        end else if (state == SW_SLOT && next_state == SW_IDLE && readSlot) begin
            txHeld    <= 1'b0;
        end
    end

    // Pull-down: presence pulse or read zero; cleared on the same edge the hold ends
    always_ff @(posedge sys_clk or negedge rstSync_n) begin
        if (!rstSync_n) pullLow <= 1'b0;
        else            pullLow <= (next_state == SW_PRESENCE_LOW) ||
                                   (next_state == SW_SLOT && next_readSlot && !txLatched &&
                                    next_timer < TIMER_W'(READ_HOLD_CYC)); // [R08] [R09]
    end

    always_ff @(posedge sys_clk or negedge rstSync_n) begin
        if (!rstSync_n) begin
            resetSeenR <= 1'b0;
            overflowR  <= 1'b0;
        end else begin
            resetSeenR <= (state == SW_RESET_LOW) && riseEdge; // [R01]
            overflowR  <= sampleNow && !fifoInReady; // [R07]
        end
    end

endmodule : swss_link

//--- swss_link_chk.sv
`timescale 1ns/10ps
module swss_link_chk #(
    parameter int RESET_LOW_CYC = 200,
    parameter int PRES_WAIT_CYC = 20,
    parameter int PRES_LOW_CYC  = 60,
    parameter int READ_HOLD_CYC = 15,
    parameter int SAMPLE_CYC    = 15
) (
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic lineIn,
    input wire logic lineOut,
    input wire logic lineOe,
    input wire logic rxBit,
    input wire logic rxValid,
    input wire logic rxReady,
    input wire logic txBit,
    input wire logic txValid,
    input wire logic txReady,
    input wire logic resetSeen,
    input wire logic rxOverflow
);
    localparam int PW_MIN = PRES_WAIT_CYC - 2;
    localparam int PW_MAX = PRES_WAIT_CYC + 4;
    localparam int PL_MIN = PRES_LOW_CYC - 3;
    localparam int PL_MAX = PRES_LOW_CYC + 3;
    localparam int RH_MIN = READ_HOLD_CYC - 3;
    localparam int RH_MAX = READ_HOLD_CYC + 3;
    localparam int S_MIN  = SAMPLE_CYC;
    localparam int S_MAX  = SAMPLE_CYC + 8;
    logic [17:0] oeCnt;
    logic [17:0] lowCnt;
    logic [17:0] lastLow;
    logic        heldBit;
    logic        inPres;
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_n);
    // Pull length, last low length, bit taken for the next read slot
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            oeCnt   <= 18'h00000;
            lowCnt  <= 18'h00000;
            lastLow <= 18'h00000;
            heldBit <= 1'b1;
            inPres  <= 1'b0;
        end else begin
            oeCnt   <= lineOe ? oeCnt + 18'h00001 : 18'h00000;
            lowCnt  <= lineIn ? 18'h00000 : lowCnt + 18'h00001;
            lastLow <= (lineIn && lowCnt != 18'h00000) ? lowCnt : lastLow;
            heldBit <= (txValid && txReady) ? txBit : heldBit;
            inPres  <= resetSeen || (inPres && !(oeCnt != 18'h00000 && !lineOe));
        end
    end
    driveLow_a: assert property (lineOut == 1'b0)
        else $error("lineOut high");
    idleRelease_a: assert property (txReady |-> !lineOe)
        else $error("line pulled while idle");
    presDelay_a: assert property (resetSeen |-> ##[PW_MIN:PW_MAX] $rose(lineOe))
        else $error("presence start");
    presQuiet_a: assert property (resetSeen |-> !lineOe [*8])
        else $error("presence early");
    presLen_a: assert property
        ($fell(lineOe) && inPres |-> oeCnt inside {[PL_MIN:PL_MAX]})
        else $error("presence length");
    readLen_a: assert property
        ($fell(lineOe) && !inPres |-> oeCnt inside {[RH_MIN:RH_MAX]})
        else $error("read hold length");
    readZero_a: assert property
        ($fell(lineIn) && !txReady && !lineOe && !heldBit |-> ##[1:250] lineOe)
        else $error("read zero late");
    readOne_a: assert property
        ($fell(lineIn) && !txReady && !lineOe && heldBit |-> !lineOe [*8])
        else $error("read one pulled");
    writeSample_a: assert property
        ($fell(lineIn) && txReady && !rxValid && !rxReady && !lineOe
            |-> ##[S_MIN:S_MAX] rxValid)
        else $error("write bit missing");
    resetLen_a: assert property (resetSeen |-> lastLow >= RESET_LOW_CYC - 4)
        else $error("reset too short");
    oeBound_a: assert property (oeCnt <= PRES_LOW_CYC + 8)
        else $error("line held too long");
    presSeen_c: cover property ($rose(lineOe) && inPres);
    readZero_c: cover property ($rose(lineOe) && !inPres);
    overflow_c: cover property (rxOverflow);
endmodule : swss_link_chk

bind swss_link swss_link_chk #(.RESET_LOW_CYC(RESET_LOW_CYC), .PRES_WAIT_CYC(PRES_WAIT_CYC),
    .PRES_LOW_CYC(PRES_LOW_CYC), .READ_HOLD_CYC(READ_HOLD_CYC), .SAMPLE_CYC(SAMPLE_CYC))
    i_swss_link_chk (.sys_clk, .rst_n, .lineIn, .lineOut, .lineOe, .rxBit, .rxValid,
    .rxReady, .txBit, .txValid, .txReady, .resetSeen, .rxOverflow);

//--- swss_master_model.sv
`timescale 1ns/10ps
module swss_master_model #(
    parameter int RLOW = 200
) (
    input  wire logic sys_clk,
    input  wire logic devOe,
    output      logic lineLvl
);
    logic mDrive = 1'b0;
    // Pullup wins unless a party pulls low
    assign lineLvl = !(mDrive || devOe);
    task automatic busReset(output logic pres);
        pres = 1'b0;
        mDrive <= 1'b1;
        repeat (RLOW + 20) @(posedge sys_clk);
        mDrive <= 1'b0;
        repeat (RLOW + 20) begin
            @(posedge sys_clk);
            if (lineLvl === 1'b0) pres = 1'b1;
        end
    endtask : busReset
    task automatic slot(input logic bitOut, input logic rd, output logic smp);
        int lowN;
        lowN = rd ? 2 : (bitOut ? 3 : 30);
        mDrive <= 1'b1;
        for (int i = 0; i < 45; i++) begin
            @(posedge sys_clk);
            if (i == lowN - 1) mDrive <= 1'b0;
            if (i == 10) smp = lineLvl;
        end
    endtask : slot
endmodule : swss_master_model

//--- swss_link_tb_top.sv
`timescale 1ns/10ps
module swss_link_tb_top;
    logic sys_clk = 1'b0;
    logic rst_n   = 1'b0;
    logic rxReady = 1'b0;
    logic txBit   = 1'b0;
    logic txValid = 1'b0;
    logic chk     = 1'b0;
    logic lineLvl, lineOut, lineOe, rxBit, rxValid, txReady, resetSeen, rxOverflow;
    logic pres, smp, b;
    int   n_errors = 0;
    int   cmp_count = 0;
    int   nOvf = 0;
    int   nRst = 0;
    int   seed = 60929;
    logic q[$];
    always #2 sys_clk = ~sys_clk;
    swss_link #(.RESET_LOW_CYC(200), .PRES_WAIT_CYC(20), .PRES_LOW_CYC(60),
        .READ_HOLD_CYC(15), .SAMPLE_CYC(15)) i_swss_link (.sys_clk, .rst_n,
        .lineIn(lineLvl), .lineOut, .lineOe, .rxBit, .rxValid, .rxReady, .txBit,
        .txValid, .txReady, .resetSeen, .rxOverflow);
    swss_master_model i_swss_master_model (.sys_clk, .devOe(lineOe), .lineLvl);
    task automatic cmpBit(input string what, input logic exp, input logic got);
        cmp_count++;
        if (got !== exp) begin
            n_errors++;
            $display("mismatch %s expected %b seen %b", what, exp, got);
        end
    endtask : cmpBit
    task automatic cmpNum(input string what, input int exp, input int got);
        cmp_count++;
        if (got != exp) begin
            n_errors++;
            $display("mismatch %s expected %0d seen %0d", what, exp, got);
        end
    endtask : cmpNum
    task automatic final_report;
        $display("errors %0d comparisons %0d", n_errors, cmp_count);
        if (n_errors == 0 && cmp_count > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask : final_report
    task automatic offer(input logic v);
        int k;
        for (k = 0; k < 100 && txReady !== 1'b1; k++) @(posedge sys_clk);
        if (k == 100) begin
            cmpBit("txReady wait", 1'b1, 1'b0);
            final_report();
        end
        txBit <= v;
        txValid <= 1'b1;
        @(posedge sys_clk);
        txValid <= 1'b0;
    endtask : offer
    always @(posedge sys_clk) begin
        if (rxOverflow === 1'b1) nOvf++;
        if (resetSeen === 1'b1) nRst++;
        if (chk && rxValid === 1'b1 && rxReady === 1'b1) begin
            if (q.size() > 0) cmpBit("rxBit", q.pop_front(), rxBit);
            else cmpNum("rx extra", 0, 1);
        end
    end
    initial begin
        repeat (10) @(posedge sys_clk);
        rst_n <= 1'b1;
        repeat (4) @(posedge sys_clk);
        i_swss_master_model.busReset(pres);
        cmpBit("presence", 1'b1, pres);
        rxReady <= 1'b1;
        repeat (4) @(posedge sys_clk);
        rxReady <= 1'b0;
        chk <= 1'b1;
        for (int i = 0; i < 18; i++) begin
            b = 1'($random(seed));
            if (i < 16) q.push_back(b);
            i_swss_master_model.slot(b, 1'b0, smp);
        end
        cmpNum("overflows", 2, nOvf);
        for (int k = 0; k < 200 && q.size() > 0; k++) begin
            rxReady <= 1'($random(seed));
            @(posedge sys_clk);
        end
        cmpNum("rx left", 0, q.size());
        rxReady <= 1'b0;
        chk <= 1'b0;
        for (int i = 0; i < 8; i++) begin
            b = 1'($random(seed));
            offer(b);
            i_swss_master_model.slot(1'b1, 1'b1, smp);
            cmpBit("read bit", b, smp);
        end
        offer(1'b0);
        i_swss_master_model.busReset(pres);
        cmpBit("presence again", 1'b1, pres);
        cmpBit("txReady after reset", 1'b1, txReady);
        cmpNum("reset count", 2, nRst);
        final_report();
    end
endmodule : swss_link_tb_top
